// ---- common/nand_host_pkg.sv ----
package nand_host_pkg;
   // command codes
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_READ_GO = 8'h30;
   localparam logic [7:0] CMD_PROG = 8'h80;
   localparam logic [7:0] CMD_PROG_GO = 8'h10;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_RESET = 8'hff;
   // status bit positions
   localparam int ST_READY_BIT = 6;
   localparam int ST_FAIL_BIT = 0;
   // page geometry
   localparam int PAGE_BYTES = 2112;
   localparam int PAGE_WORDS = 1056;
   localparam int MARK_COL_X8 = 2048;
   localparam int MARK_COL_X16 = 1024;
   // pin timing, in ns, and cycles at 8 ns
   localparam int CLK_NS = 8;
   localparam int T_WC_NS = 80;
   localparam int T_WP_NS = 60;
   localparam int T_WB_NS = 100;
   localparam int T_WHR_NS = 60;
   localparam int T_RP_NS = 60;
   localparam int T_REA_NS = 75;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WH_CYC = (T_WC_NS - T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
   localparam int RP_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int RH_CYC = (T_WC_NS - T_RP_NS + CLK_NS - 1) / CLK_NS;
   // address cycle counts
   localparam int ADDR_CYC_RW = 4;
   localparam int ADDR_CYC_ERASE = 2;
endpackage

// ---- hdl/nand_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// [RULE1] device finishes array-to-register move within 25 us, busy low
// [RULE2] reset during read/program/erase ends within 5/10/500 us
// [RULE3] reset issued while ready keeps device busy at most 5 us
// [RULE4] unmarked locations read all ones after shipping
// [RULE5] bad blocks marked non-erased at spare column, page one or two
// [RULE6] block zero is always valid
// [RULE7] host scans factory marks first, never erases them, maps bad out; not done here, erase accepts any row
// [RULE8] failed program or erase status makes host retire the block; here fail is only reported on o_fail
// [RULE9] replacement writes failed page n first, then pages 1 to n-1; no replacement here
// [RULE10] single-bit errors best fixed by ECC, not replacement; no ECC here, raw data out
// [RULE11] host may drop chip select during data load or stream
// [RULE12] address cycles: col low, col high, row low, row high
// [RULE13] word variant: upper data lines zero in command/address cycles
// [RULE14] page transfer up to 2112 bytes or 1056 words
// [RULE15] read: 00h, address cycles, 30h, then busy
// [RULE16] program: 80h, address, data, 10h confirm
// [RULE17] status bit 6 ready, bit 0 fail
// [RULE18] while busy only status or reset; wait ready before next step
// [RULE19] device drops ready/busy within bounded delay after confirm
module nand_host #(
   parameter int DW = 8,
   parameter int COLW = 12,
   parameter int ROWW = 16,
   parameter int BUSY_TMO = 80000
) (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // command port
   input wire logic i_start,
   input wire logic [1:0] i_op,
   input wire logic [COLW-1:0] i_col,
   input wire logic [ROWW-1:0] i_row,
   input wire logic [11:0] i_len,
   output logic o_busy,
   output logic o_done,
   output logic o_fail,
   output logic o_timeout,
   // write data stream
   input wire logic [DW-1:0] i_wdata,
   input wire logic i_wvalid,
   output logic o_wready,
   // read data stream
   output logic [DW-1:0] o_rdata,
   output logic o_rvalid,
   // flash pins
   output logic o_ce_n,
   output logic o_cle,
   output logic o_ale,
   output logic o_we_n,
   output logic o_re_n,
   output logic [DW-1:0] o_io,
   output logic o_io_oe,
   input wire logic [DW-1:0] i_io,
   input wire logic i_rb
);
   // op codes on i_op: 0 read, 1 program, 2 erase, 3 reset
   typedef enum {S_IDLE, S_CMD1, S_ADDR, S_WB, S_WAIT, S_STREAM,
      S_WDATA, S_CMD2, S_STCMD, S_STRD, S_DONE} state_t;
   typedef enum {P_IDLE, P_WLOW, P_WHIGH, P_RLOW, P_RHIGH} phase_t;

   state_t st_r, st_nxt;
   phase_t ph_r;
   logic [1:0] op_r;
   logic [COLW-1:0] col_r;
   logic [ROWW-1:0] row_r;
   logic [11:0] len_r, cnt_r;
   logic [2:0] acnt_r;
   logic [16:0] tmr_r;
   logic [7:0] pcnt_r;
   logic fail_r, tmo_r, done_r, rvalid_r;
   logic [DW-1:0] rdata_r;
   logic cle_r, ale_r, we_r, re_r, oe_r, ce_r;
   logic [DW-1:0] io_r;

   // select the byte for each address cycle
   function automatic logic [7:0] addr_byte(input logic [2:0] idx,
      input logic [31:0] a);
      addr_byte = a[8*idx +: 8];
   endfunction

   wire logic [31:0] full_addr;
   wire logic [31:0] row_only;
   wire logic [2:0] addr_cycles;
   wire logic [7:0] first_cmd;
   wire logic [7:0] confirm_cmd;
   wire logic pin_idle;
   wire logic [7:0] abyte;
   // [RULE12] [RULE7] [RULE9] address byte order
   assign full_addr = {{(16-ROWW){1'b0}}, row_r,
      {(16-COLW){1'b0}}, col_r};
   assign row_only = {16'h0000, {(16-ROWW){1'b0}}, row_r};
   assign addr_cycles = (op_r == 2'd2) ? 3'(nand_host_pkg::ADDR_CYC_ERASE)
      : 3'(nand_host_pkg::ADDR_CYC_RW);
   assign abyte = addr_byte(acnt_r, (op_r == 2'd2) ? row_only : full_addr);
   // [RULE15] [RULE16] command pairs
   assign first_cmd = (op_r == 2'd0) ? nand_host_pkg::CMD_READ :
      (op_r == 2'd1) ? nand_host_pkg::CMD_PROG :
      (op_r == 2'd2) ? nand_host_pkg::CMD_ERASE : nand_host_pkg::CMD_RESET;
   assign confirm_cmd = (op_r == 2'd0) ? nand_host_pkg::CMD_READ_GO :
      (op_r == 2'd1) ? nand_host_pkg::CMD_PROG_GO :
      nand_host_pkg::CMD_ERASE_GO;
   assign pin_idle = (ph_r == P_IDLE);

   // next state on start, pin-cycle completion, WB timer or ready
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         S_IDLE: if (i_start) st_nxt = S_CMD1;
         S_CMD1: if (pin_idle && done_r)
            st_nxt = (op_r == 2'd3) ? S_WB : S_ADDR;
         S_ADDR: if (pin_idle && done_r && acnt_r == addr_cycles)
            st_nxt = (op_r == 2'd1) ? S_WDATA : S_CMD2;
         S_WDATA: if (pin_idle && done_r && cnt_r == len_r)
            st_nxt = S_CMD2;
         S_CMD2: if (pin_idle && done_r) st_nxt = S_WB;
         S_WB: if (tmr_r == 17'(nand_host_pkg::WB_CYC)) st_nxt = S_WAIT;
         S_WAIT: if (i_rb)
            st_nxt = (op_r == 2'd0) ? S_STREAM :
               (op_r == 2'd3) ? S_DONE : S_STCMD;
         S_STREAM: if (pin_idle && done_r && cnt_r == len_r)
            st_nxt = S_DONE;
         S_STCMD: if (pin_idle && done_r) st_nxt = S_STRD;
         S_STRD: if (pin_idle && done_r) st_nxt = S_DONE;
         S_DONE: st_nxt = S_IDLE;
         default: st_nxt = S_IDLE;
      endcase
   end

   // main sequencer
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         st_r <= S_IDLE;
         ph_r <= P_IDLE;
         op_r <= 2'd0;
         col_r <= '0;
         row_r <= '0;
         len_r <= 12'h000;
         cnt_r <= 12'h000;
         acnt_r <= 3'h0;
         tmr_r <= 17'h00000;
         pcnt_r <= 8'h00;
         fail_r <= 1'b0;
         tmo_r <= 1'b0;
         done_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         cle_r <= 1'b0;
         ale_r <= 1'b0;
         we_r <= 1'b1;
         re_r <= 1'b1;
         oe_r <= 1'b0;
         ce_r <= 1'b1;
         io_r <= '0;
      end else begin
         st_r <= st_nxt;
         rvalid_r <= 1'b0;
         done_r <= 1'b0;
         if (st_r != st_nxt) begin
            acnt_r <= 3'h0;
            cnt_r <= 12'h000;
            tmr_r <= 17'h00000;
         end
         case (ph_r)
            P_IDLE: begin
               pcnt_r <= 8'h00;
               // [RULE13] upper lines zero for cmd/address
               if (!done_r && st_nxt == st_r) begin
                  if (st_r == S_CMD1 || st_r == S_CMD2 ||
                     st_r == S_STCMD) begin
                     ce_r <= 1'b0;
                     cle_r <= 1'b1;
                     oe_r <= 1'b1;
                     we_r <= 1'b0;
                     io_r <= DW'(st_r == S_CMD1 ? first_cmd :
                        st_r == S_CMD2 ? confirm_cmd :
                        nand_host_pkg::CMD_STATUS);
                     ph_r <= P_WLOW;
                  end else if (st_r == S_ADDR) begin
                     ce_r <= 1'b0;
                     ale_r <= 1'b1;
                     oe_r <= 1'b1;
                     we_r <= 1'b0;
                     io_r <= DW'(abyte);
                     ph_r <= P_WLOW;
                  end else if (st_r == S_WDATA) begin
                     // [RULE11] chip select lifted while data stalls
                     ce_r <= !i_wvalid;
                     if (i_wvalid) begin
                        oe_r <= 1'b1;
                        we_r <= 1'b0;
                        io_r <= i_wdata;
                        ph_r <= P_WLOW;
                     end
                  end else if (st_r == S_STREAM || st_r == S_STRD) begin
                     ce_r <= 1'b0;
                     oe_r <= 1'b0;
                     if (tmr_r >= 17'(nand_host_pkg::WHR_CYC)) begin
                        re_r <= 1'b0;
                        ph_r <= P_RLOW;
                     end
                  end else begin
                     oe_r <= 1'b0;
                     if (st_r == S_IDLE) ce_r <= 1'b1;
                  end
               end
            end
            P_WLOW: begin
               pcnt_r <= pcnt_r + 8'h01;
               if (pcnt_r == 8'(nand_host_pkg::WP_CYC - 1)) begin
                  we_r <= 1'b1;
                  pcnt_r <= 8'h00;
                  ph_r <= P_WHIGH;
               end
            end
            P_WHIGH: begin
               pcnt_r <= pcnt_r + 8'h01;
               if (pcnt_r == 8'(nand_host_pkg::WH_CYC - 1)) begin
                  cle_r <= 1'b0;
                  ale_r <= 1'b0;
                  done_r <= 1'b1;
                  ph_r <= P_IDLE;
                  if (st_r == S_ADDR) acnt_r <= acnt_r + 3'h1;
                  if (st_r == S_WDATA) cnt_r <= cnt_r + 12'h001;
               end
            end
            P_RLOW: begin
               pcnt_r <= pcnt_r + 8'h01;
               if (pcnt_r == 8'(nand_host_pkg::RP_CYC - 1)) begin
                  re_r <= 1'b1;
                  rdata_r <= i_io;
                  pcnt_r <= 8'h00;
                  ph_r <= P_RHIGH;
                  // [RULE17] [RULE8] status fail bit
                  if (st_r == S_STRD)
                     fail_r <= i_io[nand_host_pkg::ST_FAIL_BIT];
                  else
                     rvalid_r <= 1'b1;
               end
            end
            P_RHIGH: begin
               pcnt_r <= pcnt_r + 8'h01;
               if (pcnt_r == 8'(nand_host_pkg::RH_CYC - 1)) begin
                  done_r <= 1'b1;
                  ph_r <= P_IDLE;
                  if (st_r == S_STREAM) cnt_r <= cnt_r + 12'h001;
               end
            end
            default: ph_r <= P_IDLE;
         endcase
         if (st_r == S_STREAM || st_r == S_STRD || st_r == S_WB) begin
            if (pin_idle && tmr_r < 17'(nand_host_pkg::WHR_CYC) &&
               st_r != S_WB)
               tmr_r <= tmr_r + 17'h00001;
            if (st_r == S_WB && st_nxt == S_WB) tmr_r <= tmr_r + 17'h00001;
         end
         // [RULE18] wait for ready, bounded by timeout
         if (st_r == S_WAIT) begin
            if (st_nxt == S_WAIT) tmr_r <= tmr_r + 17'h00001;
            if (tmr_r == 17'(BUSY_TMO)) begin
               tmo_r <= 1'b1;
               st_r <= S_DONE;
            end
         end
         if (st_r == S_IDLE && i_start) begin
            op_r <= i_op;
            col_r <= i_col;
            row_r <= i_row;
            // [RULE14] clamp transfer length to one page
            len_r <= (i_len == 12'h000 || i_len > 12'(
               DW > 8 ? nand_host_pkg::PAGE_WORDS :
               nand_host_pkg::PAGE_BYTES)) ? 12'(DW > 8 ?
               nand_host_pkg::PAGE_WORDS : nand_host_pkg::PAGE_BYTES)
               : i_len;
            fail_r <= 1'b0;
            tmo_r <= 1'b0;
         end
      end
   end

   // [RULE10] outputs from flops, raw data
   assign o_ce_n = ce_r;
   assign o_cle = cle_r;
   assign o_ale = ale_r;
   assign o_we_n = we_r;
   assign o_re_n = re_r;
   assign o_io = io_r;
   assign o_io_oe = oe_r;
   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;
   assign o_fail = fail_r;
   assign o_timeout = tmo_r;
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_wready <= 1'b0;
      end else begin
         o_busy <= (st_nxt != S_IDLE);
         o_done <= (st_r == S_DONE);
         o_wready <= (st_nxt == S_WDATA) && pin_idle && !done_r
            && i_wvalid && st_r == S_WDATA;
      end
   end
   wire logic unused_ok;
   assign unused_ok = ^row_only[31:16];
endmodule
`default_nettype wire

// ---- tb/nand_host_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module nand_host_properties #(
   parameter int DW = 8
) (
   // clock, reset, request
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_start,
   input wire logic i_rb,
   // status
   input wire logic o_busy,
   input wire logic o_done,
   // flash pins
   input wire logic o_ce_n,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_we_n,
   input wire logic o_re_n,
   input wire logic o_io_oe,
   input wire logic [DW-1:0] o_io
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   // pin and handshake relations
   latch_excl_a:
      assert property (!(o_cle && o_ale)) else $error("cle and ale both high");
   strobe_excl_a:
      assert property (!(!o_we_n && !o_re_n)) else $error("both strobes low");
   write_drive_a:
      assert property (!o_we_n |-> o_io_oe && !o_ce_n)
      else $error("write strobe without bus drive");
   read_release_a:
      assert property (!o_re_n |-> !o_io_oe) else $error("host drives in read");
   ready_read_a:
      assert property ($fell(o_re_n) |-> i_rb) else $error("read while busy");
   start_busy_a:
      assert property (i_start && !o_busy |=> o_busy) else $error("start lost");
   done_pulse_a:
      assert property (o_done |=> !o_done) else $error("done longer than one");
   we_width_a:
      assert property ($fell(o_we_n) |-> !o_we_n [*8] ##1 o_we_n)
      else $error("write strobe width wrong");
   confirm_wait_a:
      assert property ($rose(o_we_n) && o_cle && o_io[7:0] == 8'h30
         |-> o_re_n [*8]) else $error("read strobe too soon after confirm");
endmodule
bind nand_host nand_host_properties #(.DW(DW)) u_props (.I_CLK(I_CLK),
   .I_SYS_RST(I_SYS_RST), .i_start(i_start), .i_rb(i_rb), .o_busy(o_busy),
   .o_done(o_done), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
   .o_we_n(o_we_n), .o_re_n(o_re_n), .o_io_oe(o_io_oe), .o_io(o_io));
`default_nettype wire

// ---- tb/nand_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module nand_flash_model #(
   parameter int T_RD = 300,
   parameter int T_PG = 400,
   parameter int T_ER = 500,
   parameter int T_RST = 40
) (
   // pins from host
   input wire logic i_clk,
   input wire logic i_ce_n,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_we_n,
   input wire logic i_re_n,
   input wire logic [7:0] i_io,
   // fault controls
   input wire logic i_fail,
   input wire logic i_stuck,
   // pins to host
   output logic [7:0] o_dq,
   output logic o_rdy
);
   logic [7:0] mem [int];
   logic [7:0] dq_r = 8'h00;
   logic [11:0] col_r = 12'h000;
   logic [15:0] row_r = 16'h0000;
   logic we_q = 1'b1;
   logic re_q = 1'b1;
   logic stat_r = 1'b0;
   logic fail_r = 1'b0;
   int acnt_r = 0;
   int cnt_r = 0;
   // factory mark in block one, block zero clean
   initial mem[{16'd64, 12'd2048}] = 8'h00;
   // no pull-up: a released bus shows the inverse
   assign o_dq = (!i_ce_n && !i_re_n) ? dq_r : ~dq_r;
   assign o_rdy = (cnt_r == 0) && !i_stuck;
   // latch writes on rising WE, load read data on falling RE, state kept
   always @(posedge i_clk) begin
      we_q <= i_we_n;
      re_q <= i_re_n;
      if (cnt_r > 0) cnt_r <= cnt_r - 1;
      if (!we_q && i_we_n && !i_ce_n) begin
         if (i_cle) begin
            acnt_r <= (i_io == 8'h60) ? 2 : 0;
            stat_r <= (i_io == 8'h70);
            case (i_io)
               8'h30: cnt_r <= T_RD;
               8'h10, 8'hd0: begin
                  cnt_r <= (i_io == 8'h10) ? T_PG : T_ER;
                  fail_r <= i_fail;
               end
               8'hff: cnt_r <= T_RST;
               default: ;
            endcase
         end else if (i_ale) begin
            case (acnt_r)
               0: col_r[7:0] <= i_io;
               1: col_r[11:8] <= i_io[3:0];
               2: row_r[7:0] <= i_io;
               default: row_r[15:8] <= i_io;
            endcase
            acnt_r <= acnt_r + 1;
         end else begin
            mem[{row_r, col_r}] = i_io;
            col_r <= col_r + 12'h001;
         end
      end
      if (re_q && !i_re_n) begin
         if (stat_r) dq_r <= {1'b1, o_rdy, 5'h00, fail_r};
         else if (mem.exists({row_r, col_r})) dq_r <= mem[{row_r, col_r}];
         else dq_r <= 8'hff;
      end
      if (!re_q && i_re_n && !stat_r) col_r <= col_r + 12'h001;
   end
endmodule
`default_nettype wire

// ---- tb/tb_nand_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_nand_host;
   logic clk = 1'b0, rst = 1'b1, start = 1'b0, wvalid = 1'b0;
   logic fail_inj = 1'b0, stuck = 1'b0;
   logic [1:0] op = 2'h0;
   logic [11:0] col = 12'h000, len = 12'h000, c, n;
   logic [15:0] row = 16'h0000, r;
   logic [7:0] wdata = 8'h00, rdata, io_o, dq, bus;
   logic busy, done, fail, tmo, wready, rvalid;
   logic ce_n, cle, ale, we_n, re_n, io_oe, rb;
   logic [7:0] wq [$], rq [$], shadow [int];
   int n_errors = 0, check_count = 0;
   // clock
   initial forever #4 clk = ~clk;
   assign bus = io_oe ? io_o : dq;
   nand_host #(.DW(8), .BUSY_TMO(3000)) DUT (.I_CLK(clk), .I_SYS_RST(rst),
      .i_start(start), .i_op(op), .i_col(col), .i_row(row), .i_len(len),
      .o_busy(busy), .o_done(done), .o_fail(fail), .o_timeout(tmo),
      .i_wdata(wdata), .i_wvalid(wvalid), .o_wready(wready),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_ce_n(ce_n), .o_cle(cle),
      .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n), .o_io(io_o),
      .o_io_oe(io_oe), .i_io(bus), .i_rb(rb));
   nand_flash_model FLASH (.i_clk(clk), .i_ce_n(ce_n), .i_cle(cle),
      .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n), .i_io(bus),
      .i_fail(fail_inj), .i_stuck(stuck), .o_dq(dq), .o_rdy(rb));
   // expected array contents
   function automatic logic [7:0] exp_byte(logic [15:0] a, logic [11:0] b);
      if (shadow.exists({a, b})) return shadow[{a, b}];
      return (a == 16'd64 && b == 12'd2048) ? 8'h00 : 8'hff;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one operation, feeding write words and collecting read words
   task automatic run_op(logic [1:0] o, logic [15:0] a, logic [11:0] b,
         logic [11:0] m);
      int k, idx, gap;
      k = 0;
      idx = 0;
      gap = 0;
      rq.delete();
      op = o;
      row = a;
      col = b;
      len = m;
      wdata = wq[0];
      wvalid = (o == 2'd1);
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      while (done !== 1'b1 && tmo !== 1'b1 && k < 20000) begin
         @(posedge clk);
         #1 k++;
         if (wready === 1'b1) begin
            idx++;
            gap = $urandom_range(0, 20);
         end
         if (o == 2'd1) wvalid = (gap == 0);
         if (gap > 0) gap--;
         if (rvalid === 1'b1) rq.push_back(rdata);
         if (idx < wq.size()) wdata = wq[idx];
      end
      wvalid = 1'b0;
      check(16'(k < 20000), 16'h0001);
   endtask
   // main sequence
   initial begin
      void'($urandom(32'hcafdf51f));
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      wq.push_back(8'h00);
      run_op(2'd3, 16'h0000, 12'h000, 12'h000);
      check(16'(busy), 16'h0000);
      for (int t = 0; t < 4; t++) begin
         r = 16'($urandom_range(1, 63));
         c = 12'($urandom_range(0, 2100));
         n = 12'($urandom_range(1, 6));
         wq.delete();
         for (int i = 0; i < n; i++) begin
            wq.push_back(8'($urandom));
            shadow[{r, c + 12'(i)}] = wq[i];
         end
         run_op(2'd1, r, c, n);
         check(16'(fail), 16'h0000);
         run_op(2'd0, r, c, n);
         check(16'(rq.size()), 16'(n));
         foreach (rq[i]) check(rq[i], exp_byte(r, c + 12'(i)));
      end
      // factory mark, then erased last columns of block zero
      run_op(2'd0, 16'd64, 12'd2047, 12'd3);
      foreach (rq[i]) check(rq[i], exp_byte(16'd64, 12'd2047 + 12'(i)));
      run_op(2'd0, 16'd0, 12'd2109, 12'd3);
      foreach (rq[i]) check(rq[i], exp_byte(16'd0, 12'd2109 + 12'(i)));
      run_op(2'd2, 16'd128, 12'h000, 12'h000);
      check(16'(fail), 16'h0000);
      // injected program failure must be reported
      fail_inj = 1'b1;
      run_op(2'd1, 16'd130, 12'd8, 12'd1);
      check(16'(fail), 16'h0001);
      fail_inj = 1'b0;
      // device never ready: host gives up
      stuck = 1'b1;
      run_op(2'd0, 16'd3, 12'h000, 12'd1);
      check(16'(tmo), 16'h0001);
      final_report;
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      final_report;
   end
endmodule
`default_nettype wire
